// [ufd_pkg.sv]
// Package: register map, field layout and types for the UART data-port and DMA-request block
`default_nettype none
package ufd_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DEPTH         = 32;
  localparam int          PTR_W         = 5;
  localparam int          CNT_W         = 6;
  localparam logic [7:0]  OFF_DATA      = 8'h1c;
  localparam logic [7:0]  OFF_CFG       = 8'h20;
  localparam logic [7:0]  OFF_PEEK      = 8'h24;
  localparam int          CFG_TXEN_BIT  = 0;
  localparam int          CFG_RXEN_BIT  = 1;
  localparam int          CFG_TXLVL_LSB = 8;
  localparam int          CFG_RXLVL_LSB = 16;
  localparam logic [5:0]  LVL_RST       = 6'h00;
  localparam logic [5:0]  FIFO_FULL_CNT = 6'h20;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [7:0]  PEEK_EMPTY    = 8'h00;

  // Software-visible DMA request configuration
  typedef struct packed {
    logic [5:0] rx_lvl;
    logic [5:0] tx_lvl;
    logic       rx_en;
    logic       tx_en;
  } ufd_cfg_t;

  localparam ufd_cfg_t CFG_RST = '{rx_lvl: LVL_RST, tx_lvl: LVL_RST, rx_en: 1'b0, tx_en: 1'b0};

  // Register selected by a bus address
  typedef enum logic [1:0] {SEL_NONE, SEL_DATA, SEL_CFG, SEL_PEEK} ufd_sel_t;
endpackage : ufd_pkg
`default_nettype wire

// [ufd_uart_fifo_dma.sv]
// Design: UART shared data port, receive/transmit FIFOs and DMA level requests behind AXI4-Lite
//
// Local design decision: the AXI4-Lite interface to the registers.
`default_nettype none
module ufd_uart_fifo_dma (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [ufd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                 s_axi_awprot,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [ufd_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                 s_axi_arprot,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic [7:0]                 rx_in_data,
  input  wire logic                       rx_in_valid,
  output logic                            rx_in_ready,
  output logic [7:0]                      tx_out_data,
  output logic                            tx_out_valid,
  input  wire logic                       tx_out_ready,
  output logic                            rx_dma_req,
  output logic                            tx_dma_req,
  output logic [ufd_pkg::CNT_W-1:0]       rx_level,
  output logic [ufd_pkg::CNT_W-1:0]       tx_level
);

  // Address decode shared by the read and write paths
  function automatic ufd_pkg::ufd_sel_t reg_sel(input logic [ufd_pkg::ADDR_W-1:0] addr);
    case (addr)
      ufd_pkg::OFF_DATA: reg_sel = ufd_pkg::SEL_DATA;
      ufd_pkg::OFF_CFG:  reg_sel = ufd_pkg::SEL_CFG;
      ufd_pkg::OFF_PEEK: reg_sel = ufd_pkg::SEL_PEEK;
      default:           reg_sel = ufd_pkg::SEL_NONE;
    endcase
  endfunction : reg_sel

  // Pointer advance with natural wrap at the depth
  function automatic logic [ufd_pkg::PTR_W-1:0] ptr_inc(input logic [ufd_pkg::PTR_W-1:0] p);
    ptr_inc = p + 5'h01;
  endfunction : ptr_inc

  // Storage, no reset needed on the data words
  logic [7:0]                 rx_mem [ufd_pkg::DEPTH];
  logic [7:0]                 tx_mem [ufd_pkg::DEPTH];

  logic [ufd_pkg::PTR_W-1:0]  rx_wp_r, rx_wp_nxt, rx_rp_r, rx_rp_nxt;
  logic [ufd_pkg::PTR_W-1:0]  tx_wp_r, tx_wp_nxt, tx_rp_r, tx_rp_nxt;
  logic [ufd_pkg::CNT_W-1:0]  rx_cnt_r, rx_cnt_nxt, tx_cnt_r, tx_cnt_nxt;
  ufd_pkg::ufd_cfg_t          cfg_r, cfg_nxt;
  logic                       rx_act_r, rx_act_nxt, tx_act_r, tx_act_nxt;
  logic                       rx_rdy_r, rx_rdy_nxt;
  logic [7:0]                 txo_data_r, txo_data_nxt;
  logic                       txo_valid_r, txo_valid_nxt;

  logic [ufd_pkg::ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic                       aw_have_r, aw_have_nxt;
  logic                       awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt;
  logic [31:0]                w_data_r, w_data_nxt;
  logic [3:0]                 w_strb_r, w_strb_nxt;
  logic                       w_have_r, w_have_nxt;
  logic                       bvalid_r, bvalid_nxt;
  logic [1:0]                 bresp_r, bresp_nxt;
  logic                       arready_r, arready_nxt;
  logic                       rvalid_r, rvalid_nxt;
  logic [31:0]                rdata_r, rdata_nxt;
  logic [1:0]                 rresp_r, rresp_nxt;

  logic                       rx_push, rx_pop, tx_push, tx_pop;
  logic                       do_write;
  ufd_pkg::ufd_sel_t          wsel, rsel;

  // Bus handshakes and FIFO strobes
  always_comb begin
    wsel     = reg_sel(aw_addr_r);
    rsel     = reg_sel(s_axi_araddr);
    do_write = aw_have_r && w_have_r && !bvalid_r;
    rx_push  = rx_in_valid && rx_rdy_r;
    rx_pop   = s_axi_arvalid && arready_r && (rsel == ufd_pkg::SEL_DATA) && (rx_cnt_r != 6'h00);
    tx_push  = do_write && (wsel == ufd_pkg::SEL_DATA) && w_strb_r[0]
               && (tx_cnt_r != ufd_pkg::FIFO_FULL_CNT);
    // Output stage reloads when empty or being taken by the serialiser
    tx_pop   = (!txo_valid_r || tx_out_ready) && (tx_cnt_r != 6'h00);
  end

  // Write channel: address and data taken in either order
  always_comb begin
    aw_addr_nxt = aw_addr_r;
    aw_have_nxt = aw_have_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    w_have_nxt  = w_have_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    cfg_nxt     = cfg_r;
    if (s_axi_awvalid && !aw_have_r) begin
      aw_addr_nxt = s_axi_awaddr;
      aw_have_nxt = 1'b1;
    end
    if (s_axi_wvalid && !w_have_r) begin
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
      w_have_nxt = 1'b1;
    end
    if (do_write) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = (wsel == ufd_pkg::SEL_NONE) ? ufd_pkg::RESP_SLVERR : ufd_pkg::RESP_OKAY;
      // Byte lanes steer each field; enables reset to 0 via CFG_RST
      if (wsel == ufd_pkg::SEL_CFG) begin
        if (w_strb_r[0]) begin
          cfg_nxt.tx_en = w_data_r[ufd_pkg::CFG_TXEN_BIT];
          cfg_nxt.rx_en = w_data_r[ufd_pkg::CFG_RXEN_BIT];
        end
        if (w_strb_r[1]) begin
          cfg_nxt.tx_lvl = w_data_r[ufd_pkg::CFG_TXLVL_LSB +: 6];
        end
        if (w_strb_r[2]) begin
          cfg_nxt.rx_lvl = w_data_r[ufd_pkg::CFG_RXLVL_LSB +: 6];
        end
      end
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    // Ready flags kept in their own flops so the ports come straight from registers
    awrdy_nxt = !aw_have_nxt;
    wrdy_nxt  = !w_have_nxt;
  end

  // Read channel: one read outstanding, answer one cycle after the address
  always_comb begin
    arready_nxt = arready_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    // Idle with neither flag set only right after reset: open the address channel
    if (!arready_r && !rvalid_r) begin
      arready_nxt = 1'b1;
    end
    if (s_axi_arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rdata_nxt   = 32'h0000_0000;
      rresp_nxt   = ufd_pkg::RESP_OKAY;
      case (rsel)
        ufd_pkg::SEL_DATA: begin
          // Empty receive FIFO reads as zero without moving pointers
          if (rx_cnt_r != 6'h00) begin
            rdata_nxt[7:0] = rx_mem[rx_rp_r];
          end
        end
        ufd_pkg::SEL_CFG: begin
          rdata_nxt[ufd_pkg::CFG_TXEN_BIT]        = cfg_r.tx_en;
          rdata_nxt[ufd_pkg::CFG_RXEN_BIT]        = cfg_r.rx_en;
          rdata_nxt[ufd_pkg::CFG_TXLVL_LSB +: 6]  = cfg_r.tx_lvl;
          rdata_nxt[ufd_pkg::CFG_RXLVL_LSB +: 6]  = cfg_r.rx_lvl;
        end
        ufd_pkg::SEL_PEEK: begin
          // Pure look at the head; no pointer or count changes here
          rdata_nxt[7:0] = (tx_cnt_r != 6'h00) ? tx_mem[tx_rp_r] : ufd_pkg::PEEK_EMPTY;
        end
        ufd_pkg::SEL_NONE: begin
          rresp_nxt = ufd_pkg::RESP_SLVERR;
        end
        default: begin
          rresp_nxt = ufd_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  // FIFO pointers and 6-bit occupancy counts
  always_comb begin
    rx_wp_nxt  = rx_push ? ptr_inc(rx_wp_r) : rx_wp_r;
    rx_rp_nxt  = rx_pop ? ptr_inc(rx_rp_r) : rx_rp_r;
    tx_wp_nxt  = tx_push ? ptr_inc(tx_wp_r) : tx_wp_r;
    tx_rp_nxt  = tx_pop ? ptr_inc(tx_rp_r) : tx_rp_r;
    rx_cnt_nxt = rx_cnt_r + {5'h00, rx_push} - {5'h00, rx_pop};
    tx_cnt_nxt = tx_cnt_r + {5'h00, tx_push} - {5'h00, tx_pop};
    // Registered ready stays honest since pops only lower the count
    rx_rdy_nxt = (rx_cnt_nxt != ufd_pkg::FIFO_FULL_CNT);
    txo_valid_nxt = txo_valid_r;
    txo_data_nxt  = txo_data_r;
    if (tx_pop) begin
      txo_valid_nxt = 1'b1;
      txo_data_nxt  = tx_mem[tx_rp_r];
    end else if (tx_out_ready) begin
      txo_valid_nxt = 1'b0;
    end
  end

  // DMA request latches: set once past the threshold (rx above rx_lvl, tx below tx_lvl), held until empty or full
  // Next config is used so an enable write gates the request on the same edge it lands
  always_comb begin
    rx_act_nxt = rx_act_r;
    tx_act_nxt = tx_act_r;
    if (!cfg_nxt.rx_en) begin
      rx_act_nxt = 1'b0;
    end else if (rx_cnt_nxt > cfg_nxt.rx_lvl) begin
      rx_act_nxt = 1'b1;
    end else if (rx_cnt_nxt == 6'h00) begin
      rx_act_nxt = 1'b0;
    end
    if (!cfg_nxt.tx_en) begin
      tx_act_nxt = 1'b0;
    end else if (tx_cnt_nxt == ufd_pkg::FIFO_FULL_CNT) begin
      tx_act_nxt = 1'b0;
    end else if (tx_cnt_nxt < cfg_nxt.tx_lvl) begin
      tx_act_nxt = 1'b1;
    end
  end

  // FIFO storage writes
  always_ff @(posedge aclk) begin
    if (rx_push) begin
      rx_mem[rx_wp_r] <= rx_in_data;
    end
    if (tx_push) begin
      tx_mem[tx_wp_r] <= w_data_r[7:0];
    end
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_wp_r     <= 5'h00;
      rx_rp_r     <= 5'h00;
      tx_wp_r     <= 5'h00;
      tx_rp_r     <= 5'h00;
      rx_cnt_r    <= 6'h00;
      tx_cnt_r    <= 6'h00;
      cfg_r       <= ufd_pkg::CFG_RST;
      rx_act_r    <= 1'b0;
      tx_act_r    <= 1'b0;
      rx_rdy_r    <= 1'b0;
      txo_data_r  <= 8'h00;
      txo_valid_r <= 1'b0;
      aw_addr_r   <= 8'h00;
      aw_have_r   <= 1'b0;
      w_data_r    <= 32'h0000_0000;
      w_strb_r    <= 4'h0;
      w_have_r    <= 1'b0;
      awrdy_r     <= 1'b1;
      wrdy_r      <= 1'b1;
      bvalid_r    <= 1'b0;
      bresp_r     <= 2'h0;
      arready_r   <= 1'b0;
      rvalid_r    <= 1'b0;
      rdata_r     <= 32'h0000_0000;
      rresp_r     <= 2'h0;
    end else begin
      rx_wp_r     <= rx_wp_nxt;
      rx_rp_r     <= rx_rp_nxt;
      tx_wp_r     <= tx_wp_nxt;
      tx_rp_r     <= tx_rp_nxt;
      rx_cnt_r    <= rx_cnt_nxt;
      tx_cnt_r    <= tx_cnt_nxt;
      cfg_r       <= cfg_nxt;
      rx_act_r    <= rx_act_nxt;
      tx_act_r    <= tx_act_nxt;
      rx_rdy_r    <= rx_rdy_nxt;
      txo_data_r  <= txo_data_nxt;
      txo_valid_r <= txo_valid_nxt;
      aw_addr_r   <= aw_addr_nxt;
      aw_have_r   <= aw_have_nxt;
      w_data_r    <= w_data_nxt;
      w_strb_r    <= w_strb_nxt;
      w_have_r    <= w_have_nxt;
      awrdy_r     <= awrdy_nxt;
      wrdy_r      <= wrdy_nxt;
      bvalid_r    <= bvalid_nxt;
      bresp_r     <= bresp_nxt;
      arready_r   <= arready_nxt;
      rvalid_r    <= rvalid_nxt;
      rdata_r     <= rdata_nxt;
      rresp_r     <= rresp_nxt;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awrdy_r;
  assign s_axi_wready  = wrdy_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign rx_in_ready   = rx_rdy_r;
  assign tx_out_data   = txo_data_r;
  assign tx_out_valid  = txo_valid_r;
  assign rx_dma_req    = rx_act_r;
  assign tx_dma_req    = tx_act_r;
  assign rx_level      = rx_cnt_r;
  assign tx_level      = tx_cnt_r;

endmodule : ufd_uart_fifo_dma
`default_nettype wire

// [ufd_uart_fifo_dma_props.sv]
// Checker: bus answer timing, FIFO level and DMA request relations at the block ports
`default_nettype none
module ufd_uart_fifo_dma_props (
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic                       s_axi_bvalid,
  input wire logic [ufd_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic                       s_axi_rvalid,
  input wire logic                       rx_in_valid,
  input wire logic                       rx_dma_req,
  input wire logic                       tx_dma_req,
  input wire logic [ufd_pkg::CNT_W-1:0]  rx_level,
  input wire logic [ufd_pkg::CNT_W-1:0]  tx_level
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_late;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  sequence s_rd_hs;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_b_lat; s_wr_both |=> s_b_late; endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late or early");
  property p_aw_block; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
  a_aw_block: assert property (p_aw_block) else $error("address taken twice");
  property p_r_lat; s_rd_hs |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer not next cycle");
  // A pop with no push in flight drops the count by exactly one
  property p_rx_pop;
    s_rd_hs and (s_axi_araddr == ufd_pkg::OFF_DATA && rx_level != 6'h00 && !rx_in_valid)
      |=> rx_level == $past(rx_level) - 6'h01;
  endproperty
  a_rx_pop: assert property (p_rx_pop) else $error("data read did not pop one byte");
  property p_rx_empty; rx_level == 6'h00 |-> !rx_dma_req; endproperty
  a_rx_empty: assert property (p_rx_empty) else $error("rx request with empty fifo");
  property p_tx_full; tx_level == ufd_pkg::FIFO_FULL_CNT |-> !tx_dma_req; endproperty
  a_tx_full: assert property (p_tx_full) else $error("tx request with full fifo");
  // Requests only drop at their end condition or on a config write
  property p_rx_fell; $fell(rx_dma_req) |-> rx_level == 6'h00 || $rose(s_axi_bvalid); endproperty
  a_rx_fell: assert property (p_rx_fell) else $error("rx request dropped early");
  property p_tx_fell; $fell(tx_dma_req) |-> tx_level == 6'h20 || $rose(s_axi_bvalid); endproperty
  a_tx_fell: assert property (p_tx_fell) else $error("tx request dropped early");
endmodule : ufd_uart_fifo_dma_props
bind ufd_uart_fifo_dma ufd_uart_fifo_dma_props i_ufd_uart_fifo_dma_props (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .rx_in_valid, .rx_dma_req, .tx_dma_req,
  .rx_level, .tx_level);
`default_nettype wire

// [ufd_serial_model.sv]
// Serial-side model: feeds receive bytes and sinks transmit bytes
`default_nettype none
module ufd_serial_model (
  input  wire logic       aclk,
  output logic [7:0]      rx_in_data,
  output logic            rx_in_valid,
  input  wire logic       rx_in_ready,
  input  wire logic [7:0] tx_out_data,
  input  wire logic       tx_out_valid,
  output logic            tx_out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       sink_en = 1'b0;
  logic [7:0] got[$];
  initial begin
    rx_in_data = 8'h00;
    rx_in_valid = 1'b0;
    tx_out_ready = 1'b0;
  end
  // Sink takes bytes only while enabled, so the FIFO can be held full
  always @(posedge aclk) begin
    tx_out_ready <= sink_en;
    if (tx_out_valid && tx_out_ready) got.push_back(tx_out_data);
  end
  // Byte held until taken, then inverted so a stale value never matches
  task automatic send(input logic [7:0] b);
    @(posedge aclk);
    rx_in_data <= b;
    rx_in_valid <= 1'b1;
    do @(posedge aclk); while (!rx_in_ready);
    rx_in_valid <= 1'b0;
    rx_in_data <= ~b;
    @(posedge aclk);
  endtask : send
endmodule : ufd_serial_model
`default_nettype wire

// [ufd_uart_fifo_dma_tb.sv]
// Testbench: register access, FIFO order and DMA request checks
`default_nettype none
module ufd_uart_fifo_dma_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, rx_in_valid, rx_in_ready, tx_out_valid, tx_out_ready;
  logic rx_dma_req, tx_dma_req;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, rx_in_data, tx_out_data;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [5:0] rx_level, tx_level;
  int err_count = 0, checks_done = 0, cyc = 0, i;
  ufd_uart_fifo_dma i_ufd_uart_fifo_dma (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_in_data,
    .rx_in_valid, .rx_in_ready, .tx_out_data, .tx_out_valid, .tx_out_ready, .rx_dma_req,
    .tx_dma_req, .rx_level, .tx_level);
  ufd_serial_model i_ufd_serial_model (.aclk, .rx_in_data, .rx_in_valid, .rx_in_ready,
    .tx_out_data, .tx_out_valid, .tx_out_ready);
  initial begin
    forever #25 aclk = ~aclk;
  end
  // Hang guard, far beyond the few hundred cycles the run needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  task automatic summarize();
    if (err_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Address and data offered together, each dropped at its own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_d, w_d;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    aw_d = 1'b0;
    w_d = 1'b0;
    while (!(aw_d && w_d)) begin
      @(posedge aclk);
      if (!aw_d && s_axi_awready) begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_d && s_axi_wready) begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, input string nm, input logic [31:0] exp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(nm, rd, exp);
  endtask : rchk
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(ufd_pkg::OFF_CFG, "cfg reset", 32'h0);
    rchk(ufd_pkg::OFF_PEEK, "peek empty", 32'h0);
    rchk(8'h28, "unmapped", 32'h0);
    chk("unmapped resp", 32'(rsp), 32'(ufd_pkg::RESP_SLVERR));
    wr(8'h28, 32'h0000_00ff);
    chk("unmapped wr resp", 32'(rsp), 32'(ufd_pkg::RESP_SLVERR));
    // Legal thresholds only, reserved bits set to prove they read back 0
    wr(ufd_pkg::OFF_CFG, 32'hffc3_c4fd);
    chk("cfg wr resp", 32'(rsp), 32'(ufd_pkg::RESP_OKAY));
    rchk(ufd_pkg::OFF_CFG, "cfg", 32'h0003_0401);
    chk("tx req empty", 32'(tx_dma_req), 32'h1);
    chk("rx req off", 32'(rx_dma_req), 32'h0);
    // Serialiser stalled: first byte parks in the output stage, the next 32 fill the FIFO and the last is refused
    for (i = 0; i < 34; i++) begin
      wr(ufd_pkg::OFF_DATA, 32'h10 + 32'(i));
      if (i == 1) begin
        chk("stage", 32'(tx_out_data), 32'h10);
        rchk(ufd_pkg::OFF_PEEK, "peek", 32'h11);
        rchk(ufd_pkg::OFF_PEEK, "peek again", 32'h11);
        chk("tx level peek", 32'(tx_level), 32'h1);
      end
      if (i == 9) chk("tx req above lvl", 32'(tx_dma_req), 32'h1);
    end
    chk("tx full", 32'(tx_level), 32'h20);
    chk("tx req full", 32'(tx_dma_req), 32'h0);
    i_ufd_serial_model.sink_en = 1'b1;
    do @(posedge aclk); while (tx_out_valid || tx_level != 6'h00);
    chk("tx count", 32'(i_ufd_serial_model.got.size()), 32'd33);
    for (i = 0; i < 33; i++) chk("tx byte", 32'(i_ufd_serial_model.got[i]), 32'h10 + 32'(i));
    chk("tx req again", 32'(tx_dma_req), 32'h1);
    wr(ufd_pkg::OFF_CFG, 32'h0003_0402);
    chk("tx req off", 32'(tx_dma_req), 32'h0);
    // Receive: cross the threshold, toggle the enable, then fill to the brim
    for (i = 0; i < 32; i++) begin
      i_ufd_serial_model.send(8'h40 + 8'(i));
      if (i == 2) chk("rx at lvl", 32'(rx_dma_req), 32'h0);
      if (i == 3) chk("rx above lvl", 32'(rx_dma_req), 32'h1);
      if (i == 4) begin
        wr(ufd_pkg::OFF_CFG, 32'h0003_0400);
        chk("rx disabled", 32'(rx_dma_req), 32'h0);
        wr(ufd_pkg::OFF_CFG, 32'h0003_0402);
        chk("rx enabled", 32'(rx_dma_req), 32'h1);
      end
    end
    chk("rx full", 32'(rx_level), 32'h20);
    chk("rx refuse", 32'(rx_in_ready), 32'h0);
    for (i = 0; i < 32; i++) begin
      rchk(ufd_pkg::OFF_DATA, "rx byte", 32'h40 + 32'(i));
      if (i == 29) chk("rx req held", 32'(rx_dma_req), 32'h1);
    end
    chk("rx req empty", 32'(rx_dma_req), 32'h0);
    rchk(ufd_pkg::OFF_DATA, "rx empty", 32'h0);
    summarize();
  end
endmodule : ufd_uart_fifo_dma_tb
`default_nettype wire
